// [core/sssw_defs.vh]
// Purpose: constants for the starter status word and takeover block
// Assumes: 20 MHz sys_clk
// Notes: status and control word bit positions, state codes, ramp scaling
`ifndef SSSW_DEFS_VH
`define SSSW_DEFS_VH

// status word bits
`define SSSW_ST_RSO 0
`define SSSW_ST_RDY 1
`define SSSW_ST_EN 2
`define SSSW_ST_ERR 3
`define SSSW_ST_CSTOP 4
`define SSSW_ST_QSTOP 5
`define SSSW_ST_SOI 6
`define SSSW_ST_WARN 7
`define SSSW_ST_RUN 8
`define SSSW_ST_CREQ 9
`define SSSW_ST_TOR 10
`define SSSW_ST_CL 11

// control word bits
`define SSSW_CT_ONOFF 0
`define SSSW_CT_OFF2 1
`define SSSW_CT_OFF3 2
`define SSSW_CT_ENOP 3
`define SSSW_CT_ENRAMP 4
`define SSSW_CT_UNFRZ 5
`define SSSW_CT_ENSET 6
`define SSSW_CT_FACK 7
`define SSSW_CT_TAKE 10

// drive states
`define SSSW_S_INHIB 3'h0
`define SSSW_S_READY 3'h1
`define SSSW_S_SWON 3'h2
`define SSSW_S_OPER 3'h3
`define SSSW_S_SWOFF 3'h4
`define SSSW_S_QSTOP 3'h5
`define SSSW_S_CSTOP 3'h6

// ramp and load scaling
`define SSSW_RAMP_TOP 16'hFFFF
`define SSSW_RAMP_STEP 16'h0010
`define SSSW_RAMP_QSTEP 16'h0100
`define SSSW_LOAD_100PCT 16'h4000
`define SSSW_NET_CTRL_SEL 1'b1

`endif

// [core/sssw_ramp.v]
// Purpose: ramp generator with freeze, reset and two down slopes
// Assumes: synchronous active-low reset
// Notes: freeze holds the output value exactly unless clear is asserted in the same cycle
`timescale 1ns/1ns
`default_nettype none
`include "sssw_defs.vh"
module sssw_ramp (
    // clock and reset
    input wire sys_clk,
    input wire resetn,
    // control
    input wire ramp_up,
    input wire ramp_down_fast,
    input wire ramp_freeze,
    input wire ramp_clear,
    // result
    output reg [15:0] ramp_value_reg,
    output wire ramp_at_top,
    output wire ramp_at_zero
);
    reg [15:0] ramp_value_next;
    wire [15:0] down_step;
    wire [16:0] up_sum;

    assign down_step = ramp_down_fast ? `SSSW_RAMP_QSTEP : `SSSW_RAMP_STEP;
    assign up_sum = {1'b0, ramp_value_reg} + {1'b0, `SSSW_RAMP_STEP};
    assign ramp_at_top = (ramp_value_reg == `SSSW_RAMP_TOP);
    assign ramp_at_zero = (ramp_value_reg == 16'h0000);

    always @* begin
        ramp_value_next = ramp_value_reg;
        if (ramp_clear) begin
            ramp_value_next = 16'h0000;
        end else if (ramp_freeze) begin
            ramp_value_next = ramp_value_reg;
        end else if (ramp_up) begin
            ramp_value_next = up_sum[16] ? `SSSW_RAMP_TOP : up_sum[15:0];
        end else if (ramp_value_reg > down_step) begin
            ramp_value_next = ramp_value_reg - down_step;
        end else begin
            ramp_value_next = 16'h0000;
        end
    end

    always @(posedge sys_clk) begin
        if (!resetn) begin
            ramp_value_reg <= 16'h0000;
        end else begin
            ramp_value_reg <= ramp_value_next;
        end
    end
endmodule // sssw_ramp
`default_nettype wire

// [core/sssw_top.v]
// Purpose: drive status word, load word and network takeover of a soft starter
// Assumes: process-image words synchronous to sys_clk, updated by the gateway
// Notes: words are plain ports; the gateway maps them into the cyclic image
`timescale 1ns/1ns
`default_nettype none
`include "sssw_defs.vh"
module sssw_top (
    // clock and reset
    input wire sys_clk,
    input wire resetn,
    // appended output words from host
    input wire [15:0] control_word,
    input wire [15:0] setpoint_word,
    // parameters
    input wire net_ctrl_select,
    input wire cl_report_enable,
    input wire int_cl_enable,
    input wire [15:0] rated_current,
    input wire [7:0] current_multiple,
    // measurements and faults
    input wire [15:0] motor_current,
    input wire error_present,
    input wire warning_present,
    // appended input words to host
    output reg [15:0] drive_state_word_reg,
    output reg [15:0] load_percent_word_reg,
    // power section
    output reg power_on_reg,
    output wire [15:0] ramp_level,
    output reg fail_safe_reg
);
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [15:0] ctl_eff;
    reg fack_prev_reg;
    wire take;
    wire ctrl_ok;
    wire fack_rise;
    wire [23:0] limit_full;
    wire cur_lim;
    wire host_freeze;
    wire ramp_freeze;
    wire ramp_up;
    wire ramp_fast;
    wire ramp_clear;
    wire at_top;
    wire at_zero;
    wire [31:0] load_prod;
    wire [31:0] load_scaled;
    wire [15:0] load_sat;

    assign take = control_word[`SSSW_CT_TAKE];
    // fail-safe only when the network owns the drive
    always @* begin
        if (net_ctrl_select == `SSSW_NET_CTRL_SEL && !take) begin
            ctl_eff = 16'h0000;
        end else begin
            ctl_eff = control_word;
        end
    end
    assign ctrl_ok = take;
    assign fack_rise = ctrl_ok && ctl_eff[`SSSW_CT_FACK] && !fack_prev_reg;

    // internal current limit: rated times multiple, full-width 24-bit compare
    assign limit_full = {8'h00, rated_current} * {16'h0000, current_multiple};
    assign cur_lim = int_cl_enable && ({8'h00, motor_current} >= limit_full);
    assign host_freeze = ctrl_ok && !ctl_eff[`SSSW_CT_UNFRZ];
    assign ramp_freeze = (state_reg == `SSSW_S_OPER) && (host_freeze || cur_lim);
    assign ramp_up = (state_reg == `SSSW_S_OPER) && ctl_eff[`SSSW_CT_ENRAMP]
        && ctl_eff[`SSSW_CT_ENSET];
    assign ramp_fast = (state_reg == `SSSW_S_QSTOP);
    assign ramp_clear = (state_reg == `SSSW_S_CSTOP) || (state_reg == `SSSW_S_INHIB)
        || ((state_reg == `SSSW_S_OPER) && !ctl_eff[`SSSW_CT_ENRAMP]);

    sssw_ramp u_ramp (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .ramp_up(ramp_up),
        .ramp_down_fast(ramp_fast),
        .ramp_freeze(ramp_freeze),
        .ramp_clear(ramp_clear),
        .ramp_value_reg(ramp_level),
        .ramp_at_top(at_top),
        .ramp_at_zero(at_zero)
    );

    // drive state machine; control ignored without takeover
    always @* begin
        state_next = state_reg;
        case (state_reg)
            `SSSW_S_INHIB: begin
                if (ctrl_ok && !error_present && !ctl_eff[`SSSW_CT_ONOFF]
                    && ctl_eff[`SSSW_CT_OFF2] && ctl_eff[`SSSW_CT_OFF3]) begin
                    state_next = `SSSW_S_READY;
                end
                if (fack_rise) begin
                    state_next = `SSSW_S_INHIB;
                end
            end
            `SSSW_S_READY: begin
                if (!ctrl_ok || !ctl_eff[`SSSW_CT_OFF2] || error_present) begin
                    state_next = `SSSW_S_INHIB;
                end else if (ctl_eff[`SSSW_CT_ONOFF]) begin
                    state_next = `SSSW_S_SWON;
                end
            end
            `SSSW_S_SWON: begin
                if (!ctrl_ok) begin
                    state_next = `SSSW_S_SWOFF;
                end else if (error_present || !ctl_eff[`SSSW_CT_OFF2]) begin
                    state_next = `SSSW_S_CSTOP;
                end else if (!ctl_eff[`SSSW_CT_ONOFF]) begin
                    state_next = `SSSW_S_READY;
                end else if (ctl_eff[`SSSW_CT_ENOP]) begin
                    state_next = `SSSW_S_OPER;
                end
            end
            `SSSW_S_OPER: begin
                if (!ctrl_ok) begin
                    state_next = `SSSW_S_SWOFF;
                end else if (error_present || !ctl_eff[`SSSW_CT_OFF2]
                    || !ctl_eff[`SSSW_CT_ENOP]) begin
                    state_next = `SSSW_S_CSTOP;
                end else if (!ctl_eff[`SSSW_CT_OFF3]) begin
                    state_next = `SSSW_S_QSTOP;
                end else if (!ctl_eff[`SSSW_CT_ONOFF]) begin
                    state_next = `SSSW_S_SWOFF;
                end
            end
            `SSSW_S_SWOFF: begin
                // fail-safe uses quick stop; normal off runs down the ramp
                if (!ctrl_ok || !ctl_eff[`SSSW_CT_OFF3]) begin
                    state_next = `SSSW_S_QSTOP;
                end else if (error_present || !ctl_eff[`SSSW_CT_OFF2]) begin
                    state_next = `SSSW_S_CSTOP;
                end else if (at_zero) begin
                    state_next = `SSSW_S_READY;
                end
            end
            `SSSW_S_QSTOP: begin
                if (at_zero) begin
                    state_next = `SSSW_S_INHIB;
                end else if (error_present) begin
                    state_next = `SSSW_S_CSTOP;
                end
            end
            `SSSW_S_CSTOP: begin
                state_next = `SSSW_S_INHIB;
            end
            default: begin
                state_next = `SSSW_S_INHIB;
            end
        endcase
    end

    // load: current relative to rated, 0x4000 per 100 percent, clipped at +200
    assign load_prod = {16'h0000, motor_current} * {16'h0000, `SSSW_LOAD_100PCT};
    assign load_scaled = (rated_current == 16'h0000) ? 32'h0000_0000
        : load_prod / {16'h0000, rated_current};
    assign load_sat = (load_scaled > 32'h0000_7FFF) ? 16'h7FFF : load_scaled[15:0];

    always @(posedge sys_clk) begin
        if (!resetn) begin
            state_reg <= `SSSW_S_INHIB;
            fack_prev_reg <= 1'b0;
            drive_state_word_reg <= 16'h0000;
            load_percent_word_reg <= 16'h0000;
            power_on_reg <= 1'b0;
            fail_safe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            fack_prev_reg <= ctl_eff[`SSSW_CT_FACK];
            fail_safe_reg <= (net_ctrl_select == `SSSW_NET_CTRL_SEL) && !take;
            power_on_reg <= (state_next == `SSSW_S_OPER) || (state_next == `SSSW_S_SWOFF)
                || (state_next == `SSSW_S_QSTOP);
            load_percent_word_reg <= load_sat;
            drive_state_word_reg <= 16'h0000;
            drive_state_word_reg[`SSSW_ST_RSO] <= (state_reg == `SSSW_S_READY);
            drive_state_word_reg[`SSSW_ST_RDY] <= (state_reg == `SSSW_S_SWON);
            drive_state_word_reg[`SSSW_ST_EN] <= (state_reg == `SSSW_S_OPER);
            drive_state_word_reg[`SSSW_ST_ERR] <= error_present;
            drive_state_word_reg[`SSSW_ST_WARN] <= warning_present;
            drive_state_word_reg[`SSSW_ST_CSTOP] <= (state_reg == `SSSW_S_CSTOP);
            drive_state_word_reg[`SSSW_ST_QSTOP] <= (state_reg == `SSSW_S_QSTOP);
            drive_state_word_reg[`SSSW_ST_SOI] <= (state_reg == `SSSW_S_INHIB);
            drive_state_word_reg[`SSSW_ST_RUN] <= power_on_reg;
            drive_state_word_reg[`SSSW_ST_CREQ] <=
                (net_ctrl_select == `SSSW_NET_CTRL_SEL);
            drive_state_word_reg[`SSSW_ST_TOR] <= at_top;
            drive_state_word_reg[`SSSW_ST_CL] <= cl_report_enable
                && (cur_lim || host_freeze);
        end
    end
endmodule // sssw_top
`default_nettype wire

// [sim/sssw_chk.sv]
// Purpose: port assertions for the starter status word block
// Assumes: bound to sssw_top, one clock domain
// Notes: status lags follow the hand-over timing
`timescale 1ns/1ns
`default_nettype none
module sssw_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // inputs
    input wire logic [15:0] control_word,
    input wire logic net_ctrl_select,
    input wire logic cl_report_enable,
    input wire logic error_present,
    input wire logic warning_present,
    // outputs
    input wire logic [15:0] drive_state_word_reg,
    input wire logic [15:0] load_percent_word_reg,
    input wire logic [15:0] ramp_level,
    input wire logic fail_safe_reg
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    wire logic [15:0] sw = drive_state_word_reg;
    // operating with freeze asked; stops excluded, they move the ramp
    wire logic frz = control_word[10] && control_word[5:0] == 6'h1F && !error_present && sw[2];
    chk_err_bit: assert property ($past(resetn) |-> sw[3] == $past(error_present))
        else $error("error bit wrong");
    chk_warn_bit: assert property ($past(resetn) |-> sw[7] == $past(warning_present))
        else $error("warning bit wrong");
    chk_req_bit: assert property ($past(resetn) |-> sw[9] == $past(net_ctrl_select))
        else $error("request bit wrong");
    chk_cl_quiet: assert property (!$past(cl_report_enable) |-> !sw[11])
        else $error("limit bit while off");
    chk_fail_safe: assert property ($past(resetn) |->
        fail_safe_reg == ($past(net_ctrl_select) && !$past(control_word[10])))
        else $error("fail-safe flag wrong");
    chk_spare_zero: assert property (sw[15:12] == 4'h0)
        else $error("spare status bits set");
    chk_state_once: assert property ($onehot0({sw[0], sw[1], sw[2], sw[6]}))
        else $error("two state bits set");
    chk_ramp_hold: assert property (frz [*2] |=> $stable(ramp_level))
        else $error("ramp moved while frozen");
    chk_load_sign: assert property (!load_percent_word_reg[15])
        else $error("load word negative");
endmodule // sssw_chk
bind sssw_top sssw_chk u_chk (.sys_clk, .resetn, .control_word, .net_ctrl_select,
    .cl_report_enable, .error_present, .warning_present, .drive_state_word_reg,
    .load_percent_word_reg, .ramp_level, .fail_safe_reg);
`default_nettype wire

// [sim/sssw_host.sv]
// Purpose: host controller model driving the appended control word
// Assumes: application command given by the bench
// Notes: take bit only once the request bit is seen
`timescale 1ns/1ns
`default_nettype none
module sssw_host (
    // clock
    input wire logic sys_clk,
    // application side
    input wire logic [15:0] cmd,
    input wire logic [15:0] cur_limit,
    // starter side
    input wire logic [15:0] status_word,
    input wire logic [15:0] motor_current,
    output logic [15:0] control_word
);
    logic take, over;
    always_comb take = cmd[10] && status_word[9];
    always_comb over = motor_current > cur_limit;
    initial control_word = 16'h0000;
    always @(posedge sys_clk) begin
        control_word <= {cmd[15:11], take, cmd[9:6], cmd[5] && !over, cmd[4:0]};
    end
endmodule // sssw_host
`default_nettype wire

// [sim/sssw_top_bench.sv]
// Purpose: self-checking bench for the starter status word block
// Assumes: host model sits between bench and control word
// Notes: host limit uses cur_limit, internal limit uses rated times multiple
`timescale 1ns/1ns
`default_nettype none
module sssw_top_bench;
    logic sys_clk = 1'b0, resetn = 1'b0, net_ctrl_select = 1'b1, cl_report_enable = 1'b0;
    logic int_cl_enable = 1'b0;
    logic error_present = 1'b0, warning_present = 1'b0, pwr, fs;
    logic [15:0] cmd = 16'h0000, cur_limit = 16'h0050, motor_current = 16'h0000;
    logic [15:0] control_word, sw, load, ramp;
    int n_fail = 0, checked = 0;
    initial forever #25 sys_clk = ~sys_clk;
    sssw_top dut (.sys_clk, .resetn, .control_word, .setpoint_word(16'h0000),
        .net_ctrl_select, .cl_report_enable, .int_cl_enable,
        .rated_current(16'h0040), .current_multiple(8'h02), .motor_current,
        .error_present, .warning_present, .drive_state_word_reg(sw),
        .load_percent_word_reg(load), .power_on_reg(pwr), .ramp_level(ramp),
        .fail_safe_reg(fs));
    sssw_host host (.sys_clk, .cmd, .cur_limit, .status_word(sw), .motor_current,
        .control_word);
    task automatic results;
        if (n_fail == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // polls settled values at each edge, bounded
    task automatic wait_bit(input int b, input logic v, input int lim);
        int i;
        for (i = 0; i < lim && sw[b] !== v; i++) @(posedge sys_clk);
        check("status bit", {15'h0000, sw[b]}, {15'h0000, v});
        if (sw[b] !== v) results();
    endtask
    task automatic go(input logic [15:0] c, input int b);
        @(posedge sys_clk) cmd <= c;
        wait_bit(b, 1'b1, 8);
    endtask
    task automatic t_reset;
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        wait_bit(6, 1'b1, 4);
        check("status after reset", sw, 16'h0240);
    endtask
    // 0x0006 would reach ready if the control bits were not ignored
    task automatic t_ignore;
        @(posedge sys_clk) cmd <= 16'h0006;
        repeat (6) @(posedge sys_clk);
        check("status without take", sw, 16'h0240);
        check("fail-safe", {15'h0000, fs}, 16'h0001);
        net_ctrl_select <= 1'b0;
        repeat (4) @(posedge sys_clk);
        check("local without take", sw, 16'h0040);
        check("no fail-safe", {15'h0000, fs}, 16'h0000);
        net_ctrl_select <= 1'b1;
    endtask
    task automatic t_start;
        go(16'h0406, 0);
        go(16'h0407, 1);
        go(16'h047F, 2);
        wait_bit(8, 1'b1, 8);
        check("power", {15'h0000, pwr}, 16'h0001);
    endtask
    task automatic t_freeze;
        logic [15:0] r;
        cl_report_enable <= 1'b1;
        repeat (10) @(posedge sys_clk) motor_current <= 16'h0060;
        r = ramp;
        repeat (5) @(posedge sys_clk);
        check("frozen ramp", ramp, r);
        check("limit bit", {15'h0000, sw[11]}, 16'h0001);
        cl_report_enable <= 1'b0;
        repeat (4) @(posedge sys_clk) motor_current <= 16'h0040;
        check("limit bit off", {15'h0000, sw[11]}, 16'h0000);
        // host limit out of the way: only rated times multiple may freeze
        int_cl_enable <= 1'b1;
        cur_limit <= 16'hFFFF;
        cl_report_enable <= 1'b1;
        repeat (3) @(posedge sys_clk) motor_current <= 16'h0080;
        r = ramp;
        repeat (3) @(posedge sys_clk);
        check("internal limit", ramp, r);
        check("limit bit internal", {15'h0000, sw[11]}, 16'h0001);
        int_cl_enable <= 1'b0;
        cl_report_enable <= 1'b0;
        cur_limit <= 16'h0050;
        @(posedge sys_clk) motor_current <= 16'h0040;
        wait_bit(10, 1'b1, 5000);
        check("load 100", load, 16'h4000);
        repeat (3) @(posedge sys_clk) motor_current <= 16'h0080;
        check("load 200", load, 16'h7FFF);
        @(posedge sys_clk) motor_current <= 16'h0000;
    endtask
    task automatic t_fault;
        warning_present <= 1'b1;
        wait_bit(7, 1'b1, 3);
        warning_present <= 1'b0;
        error_present <= 1'b1;
        wait_bit(3, 1'b1, 3);
        wait_bit(7, 1'b0, 3);
        error_present <= 1'b0;
        wait_bit(3, 1'b0, 3);
    endtask
    // coast stop is never entered from ready or inhibit, so start the drive first
    task automatic t_coast;
        t_start();
        go(16'h047D, 4);
        @(posedge sys_clk) cmd <= 16'h0400;
        wait_bit(6, 1'b1, 300);
    endtask
    task automatic t_failsafe;
        repeat (20) @(posedge sys_clk);
        go(16'h007F, 5);
        check("fail-safe", {15'h0000, fs}, 16'h0001);
        wait_bit(6, 1'b1, 300);
        check("ramp after stop", ramp, 16'h0000);
    endtask
    initial begin
        t_reset();
        t_ignore();
        t_start();
        t_freeze();
        t_fault();
        t_coast();
        t_start();
        t_failsafe();
        results();
    end
endmodule // sssw_top_bench
`default_nettype wire
